// ### design/adc_result_pkg.sv
// package: register offsets, widths and reset values of the adc result bank
package adc_result_pkg;
  localparam int  ADDR_W   = 8;
  localparam int  DATA_W   = 8;
  localparam int  RESULT_W = 16;

  localparam logic [ADDR_W-1:0] INPUT_CURRENT_RESULT_HIGH_ADDR  = 8'h17;
  localparam logic [ADDR_W-1:0] INPUT_CURRENT_RESULT_LOW_ADDR   = 8'h18;
  localparam logic [ADDR_W-1:0] CHARGE_CURRENT_RESULT_HIGH_ADDR = 8'h19;
  localparam logic [ADDR_W-1:0] CHARGE_CURRENT_RESULT_LOW_ADDR  = 8'h1A;
  localparam logic [ADDR_W-1:0] INPUT_VOLTAGE_RESULT_HIGH_ADDR  = 8'h1B;
  localparam logic [ADDR_W-1:0] INPUT_VOLTAGE_RESULT_LOW_ADDR   = 8'h1C;

  localparam logic [RESULT_W-1:0] RESULT_RESET   = 16'h0000;
  localparam logic [DATA_W-1:0]   READ_ZERO      = 8'h00;
  localparam logic [RESULT_W-1:0] CHARGE_MASK    = 16'h7FFF;
  localparam int                  HIGH_LSB       = 8;
  localparam int                  SIGN_BIT       = 15;

  typedef enum logic [1:0] {
    CONV_IDLE   = 2'b00,
    CONV_ACTIVE = 2'b01,
    CONV_DONE   = 2'b11
  } conv_state_t;
endpackage : adc_result_pkg

// ### design/result_word_reg.sv
// one 16-bit result holder with load mask and register reset
`timescale 1ns/1ps
module result_word_reg #(
  parameter logic [adc_result_pkg::RESULT_W-1:0] KEEP_MASK = 16'hFFFF
) (
  input  wire logic                                clk_in,
  input  wire logic                                reset_in,
  input  wire logic                                clear_in,
  input  wire logic                                load_in,
  input  wire logic [adc_result_pkg::RESULT_W-1:0] value_in,
  output logic      [adc_result_pkg::RESULT_W-1:0] word_out
);
  import adc_result_pkg::*;

  wire logic [RESULT_W-1:0] masked_value;
  assign masked_value = value_in & KEEP_MASK;

  always_ff @(posedge clk_in) begin
    if (reset_in || clear_in) begin
      word_out <= RESULT_RESET;
    end else if (load_in) begin
      word_out <= masked_value;
    end
  end
endmodule : result_word_reg

// ### design/adc_result_registers.sv
// read-only bank of adc measurement result registers
`timescale 1ns/1ps
module adc_result_registers (
  input  wire logic                                clk_in,
  input  wire logic                                reset_in,
  input  wire logic                                reg_reset_in,
  input  wire logic                                watchdog_expired_in,
  input  wire logic                                adc_enable_in,
  input  wire logic                                one_shot_in,
  input  wire logic                                conv_done_in,
  input  wire logic [adc_result_pkg::RESULT_W-1:0] input_current_sample_in,
  input  wire logic [adc_result_pkg::RESULT_W-1:0] charge_current_sample_in,
  input  wire logic [adc_result_pkg::RESULT_W-1:0] input_voltage_sample_in,
  input  wire logic                                read_in,
  input  wire logic                                write_in,
  input  wire logic [adc_result_pkg::ADDR_W-1:0]   addr_in,
  input  wire logic [adc_result_pkg::DATA_W-1:0]   wdata_in,
  output logic      [adc_result_pkg::DATA_W-1:0]   rdata_out,
  output logic                                     one_shot_busy_out
);
  import adc_result_pkg::*;

  localparam int                  RESULT_COUNT       = 3;
  localparam int                  INPUT_CURRENT_IDX  = 0;
  localparam int                  CHARGE_CURRENT_IDX = 1;
  localparam int                  INPUT_VOLTAGE_IDX  = 2;
  localparam logic [RESULT_W-1:0] FULL_MASK          = {RESULT_W{1'b1}};

  conv_state_t                                  state;
  conv_state_t                                  next_state;
  logic                                         load;
  wire logic [RESULT_COUNT-1:0][RESULT_W-1:0]   sample_word;
  wire logic [RESULT_COUNT-1:0][RESULT_W-1:0]   result_word;
  wire logic [DATA_W-1:0]                       input_current_result_high;
  wire logic [DATA_W-1:0]                       input_current_result_low;
  wire logic [DATA_W-1:0]                       charge_current_result_high;
  wire logic [DATA_W-1:0]                       charge_current_result_low;
  wire logic [DATA_W-1:0]                       input_voltage_result_high;
  wire logic [DATA_W-1:0]                       input_voltage_result_low;
  wire logic                                    sel_input_current_high;
  wire logic                                    sel_input_current_low;
  wire logic                                    sel_charge_current_high;
  wire logic                                    sel_charge_current_low;
  wire logic                                    sel_input_voltage_high;
  wire logic                                    sel_input_voltage_low;
  logic      [DATA_W-1:0]                       next_rdata;

  // sample taken only while enabled and in the active phase
  assign load = (state == CONV_ACTIVE) && adc_enable_in && conv_done_in;

  // converter sequencing: continuous keeps loading, one-shot loads once
  always_comb begin
    next_state = state;
    case (state)
      CONV_IDLE: begin
        if (adc_enable_in) begin
          next_state = CONV_ACTIVE;
        end
      end
      CONV_ACTIVE: begin
        if (!adc_enable_in) begin
          next_state = CONV_IDLE;
        end else if (conv_done_in && one_shot_in) begin
          next_state = CONV_DONE;
        end
      end
      CONV_DONE: begin
        if (!adc_enable_in) begin
          next_state = CONV_IDLE;
        end else if (!one_shot_in) begin
          next_state = CONV_ACTIVE;
        end
      end
      default: begin
        next_state = CONV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in || reg_reset_in) begin
      state <= CONV_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign one_shot_busy_out = (state == CONV_ACTIVE) && one_shot_in;

  // sample words arrive already signed: into the pin positive, out negative
  assign sample_word[INPUT_CURRENT_IDX]  = input_current_sample_in;
  assign sample_word[CHARGE_CURRENT_IDX] = charge_current_sample_in;
  assign sample_word[INPUT_VOLTAGE_IDX]  = input_voltage_sample_in;

  // one holder per measured quantity; charge current drops its top bit
  generate
    for (genvar idx = 0; idx < RESULT_COUNT; idx++) begin : g_result
      localparam logic [RESULT_W-1:0] KEEP =
        (idx == CHARGE_CURRENT_IDX) ? CHARGE_MASK : FULL_MASK;
      result_word_reg #(
        .KEEP_MASK (KEEP)
      ) u_result (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .clear_in (reg_reset_in),
        .load_in  (load),
        .value_in (sample_word[idx]),
        .word_out (result_word[idx])
      );
    end
  endgenerate

  // byte views: high byte at the lower address, low byte at the next
  assign input_current_result_high  = result_word[INPUT_CURRENT_IDX][RESULT_W-1:HIGH_LSB];
  assign input_current_result_low   = result_word[INPUT_CURRENT_IDX][HIGH_LSB-1:0];
  assign charge_current_result_high = result_word[CHARGE_CURRENT_IDX][RESULT_W-1:HIGH_LSB];
  assign charge_current_result_low  = result_word[CHARGE_CURRENT_IDX][HIGH_LSB-1:0];
  assign input_voltage_result_high  = result_word[INPUT_VOLTAGE_IDX][RESULT_W-1:HIGH_LSB];
  assign input_voltage_result_low   = result_word[INPUT_VOLTAGE_IDX][HIGH_LSB-1:0];

  // address match per register
  assign sel_input_current_high  = (addr_in == INPUT_CURRENT_RESULT_HIGH_ADDR);
  assign sel_input_current_low   = (addr_in == INPUT_CURRENT_RESULT_LOW_ADDR);
  assign sel_charge_current_high = (addr_in == CHARGE_CURRENT_RESULT_HIGH_ADDR);
  assign sel_charge_current_low  = (addr_in == CHARGE_CURRENT_RESULT_LOW_ADDR);
  assign sel_input_voltage_high  = (addr_in == INPUT_VOLTAGE_RESULT_HIGH_ADDR);
  assign sel_input_voltage_low   = (addr_in == INPUT_VOLTAGE_RESULT_LOW_ADDR);

  // unmapped addresses match nothing and read zero
  // writes and watchdog have no path into the results
  assign next_rdata = ({DATA_W{sel_input_current_high}}  & input_current_result_high)
                    | ({DATA_W{sel_input_current_low}}   & input_current_result_low)
                    | ({DATA_W{sel_charge_current_high}} & charge_current_result_high)
                    | ({DATA_W{sel_charge_current_low}}  & charge_current_result_low)
                    | ({DATA_W{sel_input_voltage_high}}  & input_voltage_result_high)
                    | ({DATA_W{sel_input_voltage_low}}   & input_voltage_result_low);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_out <= READ_ZERO;
    end else if (read_in) begin
      rdata_out <= next_rdata;
    end
  end
endmodule : adc_result_registers

// ### verif/adc_result_properties.sv
// checker: port-level properties of the adc result bank
`timescale 1ns/1ps
module adc_result_properties (
  input wire logic                              clk_in,
  input wire logic                              reset_in,
  input wire logic                              reg_reset_in,
  input wire logic                              adc_enable_in,
  input wire logic                              one_shot_in,
  input wire logic                              read_in,
  input wire logic [adc_result_pkg::ADDR_W-1:0] addr_in,
  input wire logic [adc_result_pkg::DATA_W-1:0] rdata_out,
  input wire logic                              one_shot_busy_out
);
  import adc_result_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  a_unmapped_reads_zero: assert property (read_in && (addr_in < 8'h17 || addr_in > 8'h1C)
    |=> rdata_out == 8'h00) else $error("unmapped read not zero");
  a_charge_top_zero: assert property (read_in && addr_in == 8'h19 |=> !rdata_out[7])
    else $error("charge bit 7 set");
  a_reg_reset_clears: assert property (reg_reset_in ##1 read_in |=> rdata_out == 8'h00)
    else $error("result kept over register reset");
  a_read_data_holds: assert property (!read_in |=> $stable(rdata_out))
    else $error("read data moved");
  a_release_reads_zero: assert property ($fell(reset_in) |-> rdata_out == 8'h00)
    else $error("read data not zero");
  a_busy_needs_enable: assert property (one_shot_busy_out |-> $past(adc_enable_in))
    else $error("busy while disabled");
  a_busy_after_enable: assert property ($rose(adc_enable_in) && one_shot_in &&
    !reg_reset_in |=> ##[0:1] one_shot_busy_out) else $error("one-shot never started");
  a_idle_disabled: assert property (!adc_enable_in [*2] |-> !one_shot_busy_out)
    else $error("busy after disable");
endmodule : adc_result_properties

bind adc_result_registers adc_result_properties chk_i (.clk_in, .reset_in, .reg_reset_in,
  .adc_enable_in, .one_shot_in, .read_in, .addr_in, .rdata_out, .one_shot_busy_out);

// ### verif/adc_result_registers_test.sv
// testbench of the adc result register bank
`timescale 1ns/1ps
module adc_result_registers_test;
  import adc_result_pkg::*;
  logic clk_in = 0, reset_in = 1, reg_reset_in = 0, watchdog_expired_in = 0;
  logic adc_enable_in = 0, one_shot_in = 0, conv_done_in = 0, read_in = 0, write_in = 0;
  logic [15:0] ic = 0, cc = 0, iv = 0;
  logic [7:0]  addr_in = 0, wdata_in = 0, rdata_out;
  logic        one_shot_busy_out;
  int          mismatches = 0, checked = 0, cycles = 0;
  adc_result_registers uut (.clk_in, .reset_in, .reg_reset_in, .watchdog_expired_in,
    .adc_enable_in, .one_shot_in, .conv_done_in, .input_current_sample_in(ic),
    .charge_current_sample_in(cc), .input_voltage_sample_in(iv), .read_in, .write_in,
    .addr_in, .wdata_in, .rdata_out, .one_shot_busy_out);
  initial forever #20 clk_in = ~clk_in;
  task automatic test_done();
    if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk_in);
    read_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    read_in <= 1'b0;
    #1 chk("rdata", rdata_out, e);
  endtask : rd
  task automatic rdall(logic [15:0] i, logic [15:0] c, logic [15:0] v);
    rd(8'h17, i[15:8]);
    rd(8'h18, i[7:0]);
    rd(8'h19, {1'b0, c[14:8]});
    rd(8'h1A, c[7:0]);
    rd(8'h1B, v[15:8]);
    rd(8'h1C, v[7:0]);
  endtask : rdall
  task automatic conv(logic [15:0] i, logic [15:0] c, logic [15:0] v);
    @(posedge clk_in);
    conv_done_in <= 1'b1;
    ic <= i;
    cc <= c;
    iv <= v;
    @(posedge clk_in);
    conv_done_in <= 1'b0;
  endtask : conv
  task automatic en(logic m);
    @(posedge clk_in);
    adc_enable_in <= 1'b1;
    one_shot_in <= m;
    repeat (2) @(posedge clk_in);
  endtask : en
  task automatic t_cont();
    en(1'b0);
    conv(16'hF830, 16'hFFFF, 16'h8123);
    rdall(16'hF830, 16'hFFFF, 16'h8123);
    conv(16'h0FA0, 16'h1234, 16'h2710);
    @(posedge clk_in);
    write_in <= 1'b1;
    watchdog_expired_in <= 1'b1;
    addr_in <= 8'h17;
    wdata_in <= 8'h55;
    @(posedge clk_in);
    write_in <= 1'b0;
    watchdog_expired_in <= 1'b0;
    rdall(16'h0FA0, 16'h1234, 16'h2710);
    rd(8'h20, 8'h00);
    rd(8'h16, 8'h00);
  endtask : t_cont
  task automatic t_oneshot();
    @(posedge clk_in);
    adc_enable_in <= 1'b0;
    conv(16'h0001, 16'h0001, 16'h0001);
    rdall(16'h0FA0, 16'h1234, 16'h2710);
    en(1'b1);
    #1 chk("busy", {7'h00, one_shot_busy_out}, 8'h01);
    conv(16'h8000, 16'h4000, 16'h7FFF);
    conv(16'h0002, 16'h0002, 16'h0002);
    #1 chk("busy", {7'h00, one_shot_busy_out}, 8'h00);
    rdall(16'h8000, 16'h4000, 16'h7FFF);
  endtask : t_oneshot
  task automatic t_regreset();
    @(posedge clk_in);
    reg_reset_in <= 1'b1;
    @(posedge clk_in);
    reg_reset_in <= 1'b0;
    read_in <= 1'b1;
    addr_in <= 8'h17;
    @(posedge clk_in);
    read_in <= 1'b0;
    #1 chk("cleared", rdata_out, 8'h00);
    rdall(16'h0000, 16'h0000, 16'h0000);
  endtask : t_regreset
  initial begin
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b0;
    rdall(16'h0000, 16'h0000, 16'h0000);
    t_cont();
    t_oneshot();
    t_regreset();
    test_done();
  end
endmodule : adc_result_registers_test
